// ### common/sorc_pkg.sv
package sorc_pkg;
  typedef enum logic [1:0] {sorc_pm_normal, sorc_pm_pdown, sorc_pm_standby, sorc_pm_dreset} sorc_pmode_t;
  typedef enum logic [1:0] {sorc_st_init, sorc_st_run, sorc_st_hold} sorc_state_t;
  typedef struct packed {
    logic w12;
    logic dbl;
    logic bytew;
    logic ddr;
    logic one;
  } sorc_fmt_t;
endpackage

// ### common/sorc_regs.svh
// Functional notes
// RULE1: After reset the serialization control register reads 0x30 (16-bit, 1x, DDR bytewise).
// RULE2: 16-bit single frame codes 0x20, 0x10, 0x00 pick DDR bitwise, SDR bytewise, SDR bitwise.
// RULE3: 16-bit double frame codes 0x34, 0x24, 0x14, 0x04 mirror the single frame codes.
// RULE4: 12-bit codes 0x32..0x02 single and 0x36..0x06 double frame, clock 3x or 6x.
// RULE5: Codes 0x40 and 0x42 give single-lane wordwise DDR output, single frame.
// RULE6: Override register writes stay pending until transfer register 0xFF bit 0 is set.
// RULE7: Override lowers resolution and rate capability; low three bits limit rate only.
// RULE8: Bit 0 of user I/O control 2 disconnects the serial data pin pull-down.
// RULE9: Bit 3 of user I/O control 3 powers down the common-mode generator.
// RULE10: Host recovers supply misorder with 0x3C to 0x00, then 0x03, 0x00 to 0x08.
// RULE11: Power-on runs an initialization phase from a state machine on a stable clock.
// RULE12: Host re-runs initialization by writing 0x03 then 0x00 to power mode register.
// RULE13: Host keeps the serial port idle when full converter performance matters.
// RULE14: Power mode 11 resets datapath clocks and outputs, serial port stays usable.
// RULE15: Power mode 00 runs both channels with datapath clocks and outputs active.
// RULE16: Unlisted serialization codes are reserved; hardware falls back to the default format.
`ifndef SORC_REGS_SVH
`define SORC_REGS_SVH
`define SORC_ADDR_CFG 13'h000
`define SORC_ADDR_PMODE 13'h008
`define SORC_ADDR_SERCTL 13'h021
`define SORC_ADDR_XFER 13'h0FF
`define SORC_ADDR_OVR 13'h100
`define SORC_ADDR_UIO2 13'h101
`define SORC_ADDR_UIO3 13'h102
`define SORC_CFG_RST 8'h18
`define SORC_SERCTL_RST 8'h30
`define SORC_ZERO_RST 8'h00
`define SORC_SOFT_RST_HI 5
`define SORC_SOFT_RST_LO 2
`define SORC_SER_W12 1
`define SORC_SER_DBL 2
`define SORC_SER_BYTE 4
`define SORC_SER_DDR 5
`define SORC_SER_ONE 6
`define SORC_SER_TWO_MASK 8'hC9
`define SORC_SER_ONE16 8'h40
`define SORC_SER_ONE12 8'h42
`define SORC_XFER_BIT 0
`define SORC_PULLDN_BIT 0
`define SORC_VCM_PD_BIT 3
`define SORC_RATE_MSB 2
`define SORC_RES_MSB 5
`define SORC_RES_LSB 4
`define SORC_CLK_PERIOD_NS 100
`define SORC_INIT_TIME_NS 2000
`define SORC_INIT_CYCLES ((`SORC_INIT_TIME_NS + `SORC_CLK_PERIOD_NS - 1) / `SORC_CLK_PERIOD_NS)
`define SORC_SPI_INSTR_LAST 15
`define SORC_SPI_FRAME_LAST 23
`define SORC_SPI_FRAME_BITS 24
`endif

// ### hdl/sorc_top.sv
`include "sorc_regs.svh"

// Sample FIFO; DEPTH must be a power of two so the pointers wrap on their own
module sorc_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = mem[rd_ptr];
  assign next_count = flush ? '0 : AW'(0) + count + (AW+1)'(push) - (AW+1)'(pop);

  // Storage array has no reset; only the pointers matter
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointers, fill level and registered flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      wr_ptr <= flush ? '0 : wr_ptr + AW'(push);
      rd_ptr <= flush ? '0 : rd_ptr + AW'(pop);
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

module sorc_top #(
  parameter int INIT_CYCLES = `SORC_INIT_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic spi_sclk,
  input wire logic spi_csb_n,
  input wire logic spi_sdio_in,
  output logic spi_sdio_out,
  output logic spi_sdio_oe,
  input wire logic sample_valid,
  input wire logic [13:0] sample_a,
  input wire logic [13:0] sample_b,
  output logic sample_ready,
  output logic [1:0] lane_a,
  output logic [1:0] lane_b,
  output logic bit_capture_clock_out,
  output logic word_marker_clock_out,
  output logic common_mode_voltage_output_en,
  output logic sdio_pulldown_en,
  output logic [2:0] max_rate_code,
  output logic init_done,
  output logic datapath_in_reset
);
  logic [2:0] sclk_s;
  logic [1:0] csb_s;
  logic [1:0] sdio_s;
  logic [4:0] bit_cnt;
  logic [23:0] shreg;
  logic [7:0] out_sh;
  logic rd_mode;
  logic [12:0] spi_addr;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic [7:0] cfg;
  logic [1:0] pmode;
  logic [7:0] serctl;
  logic [7:0] ovr_pending;
  logic [7:0] ovr_active;
  logic [7:0] uio2;
  logic [7:0] uio3;
  sorc_pkg::sorc_state_t state;
  logic [$clog2(INIT_CYCLES+1)-1:0] init_cnt;
  logic run;
  logic dp_clear;
  logic fifo_valid;
  logic fifo_pop;
  logic [27:0] fifo_data;
  sorc_pkg::sorc_fmt_t cur_fmt;
  sorc_pkg::sorc_fmt_t fmt;
  logic busy;
  logic half;
  logic frame_phase;
  logic [3:0] bit_idx;
  logic [15:0] word_a;
  logic [15:0] word_b;
  logic last_slot;
  logic sclk_rise;
  logic sclk_fall;

  // Unlisted codes fall back to the reset format instead of garbage lanes
  function automatic sorc_pkg::sorc_fmt_t decode_fmt(input logic [7:0] c);
    logic legal;
    logic [7:0] u;
    sorc_pkg::sorc_fmt_t f;
    legal = ((c & `SORC_SER_TWO_MASK) == 8'h00) || c == `SORC_SER_ONE16
      || c == `SORC_SER_ONE12; // RULE16
    u = legal ? c : `SORC_SERCTL_RST;
    f.w12 = u[`SORC_SER_W12]; // RULE4
    f.dbl = u[`SORC_SER_DBL]; // RULE3
    f.bytew = u[`SORC_SER_BYTE]; // RULE2
    f.ddr = u[`SORC_SER_DDR] | u[`SORC_SER_ONE]; // RULE5
    f.one = u[`SORC_SER_ONE]; // RULE5
    return f;
  endfunction

  // Last bit index on a lane for one sample
  function automatic logic [3:0] last_idx(input sorc_pkg::sorc_fmt_t f);
    if (f.one)
      return f.w12 ? 4'hB : 4'hF;
    return f.w12 ? 4'h5 : 4'h7;
  endfunction

  // Left-justified word with low bits cleared by resolution override
  function automatic logic [15:0] fmt_word(input logic [13:0] s, input logic w12,
      input logic [1:0] drop);
    logic [15:0] w;
    logic [4:0] keep;
    w = w12 ? {s[13:2], 4'h0} : {s, 2'h0};
    keep = (w12 ? 5'h0C : 5'h10) - {2'h0, drop, 1'b0};
    return w & 16'(16'hFFFF << (5'h10 - keep)); // RULE7
  endfunction

  // Pair of lane bits {upper lane, lower lane} for bit index k
  function automatic logic [1:0] lane_bits(input logic [15:0] w, input sorc_pkg::sorc_fmt_t f,
      input logic [3:0] k);
    if (f.one)
      return {1'b0, w[4'(4'hF - k)]}; // RULE5
    if (f.bytew)
      return {w[4'(4'hF - k)], w[4'((f.w12 ? 4'h9 : 4'h7) - k)]}; // RULE2
    return {w[4'(4'hF - {k[2:0], 1'b0})], w[4'(4'hE - {k[2:0], 1'b0})]}; // RULE2
  endfunction

  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];

  // Serial port pins are asynchronous; two flops before any logic looks at them
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sclk_s <= 3'h0;
      csb_s <= 2'h3;
      sdio_s <= 2'h0;
    end
    else
    begin
      sclk_s <= {sclk_s[1:0], spi_sclk};
      csb_s <= {csb_s[0], spi_csb_n};
      sdio_s <= {sdio_s[0], spi_sdio_in};
    end
  end

  // Serial port: 16-bit instruction then one data byte, MSB first
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bit_cnt <= 5'h00;
      shreg <= 24'h000000;
      out_sh <= 8'h00;
      rd_mode <= 1'b0;
      spi_addr <= 13'h0000;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      spi_sdio_out <= 1'b0;
      spi_sdio_oe <= 1'b0;
    end
    else
    begin
      wr_en <= 1'b0;
      if (csb_s[1])
      begin
        bit_cnt <= 5'h00;
        rd_mode <= 1'b0;
        spi_sdio_oe <= 1'b0;
      end
      else if (sclk_rise && bit_cnt < 5'(`SORC_SPI_FRAME_BITS))
      begin
        shreg <= {shreg[22:0], sdio_s[1]};
        bit_cnt <= bit_cnt + 5'h01;
        if (bit_cnt == 5'(`SORC_SPI_INSTR_LAST))
        begin
          rd_mode <= shreg[14];
          spi_addr <= {shreg[11:0], sdio_s[1]};
        end
        if (bit_cnt == 5'(`SORC_SPI_INSTR_LAST) && shreg[14])
          out_sh <= rd_data;
        if (bit_cnt == 5'(`SORC_SPI_FRAME_LAST) && !rd_mode)
        begin
          wr_en <= 1'b1; // RULE14
          wr_data <= {shreg[6:0], sdio_s[1]};
        end
      end
      else if (sclk_fall && rd_mode)
      begin
        spi_sdio_oe <= bit_cnt < 5'(`SORC_SPI_FRAME_BITS);
        spi_sdio_out <= out_sh[7];
        out_sh <= {out_sh[6:0], 1'b0};
      end
    end
  end

  // Read-back; instruction address is still in the shift register here
  always_comb
  begin
    case ({shreg[11:0], sdio_s[1]})
      `SORC_ADDR_CFG: rd_data = cfg;
      `SORC_ADDR_PMODE: rd_data = {6'h00, pmode};
      `SORC_ADDR_SERCTL: rd_data = serctl;
      `SORC_ADDR_OVR: rd_data = ovr_pending;
      `SORC_ADDR_UIO2: rd_data = uio2;
      `SORC_ADDR_UIO3: rd_data = uio3;
      default: rd_data = 8'h00;
    endcase
  end

  // Register file; soft reset returns every register to its default
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cfg <= `SORC_CFG_RST;
      pmode <= 2'h0;
      serctl <= `SORC_SERCTL_RST; // RULE1
      ovr_pending <= `SORC_ZERO_RST;
      ovr_active <= `SORC_ZERO_RST;
      uio2 <= `SORC_ZERO_RST;
      uio3 <= `SORC_ZERO_RST;
    end
    else if (wr_en)
    begin
      case (spi_addr)
        `SORC_ADDR_CFG:
          if (wr_data[`SORC_SOFT_RST_HI] && wr_data[`SORC_SOFT_RST_LO])
          begin
            pmode <= 2'h0;
            serctl <= `SORC_SERCTL_RST; // RULE1
            ovr_pending <= `SORC_ZERO_RST;
            ovr_active <= `SORC_ZERO_RST;
            uio2 <= `SORC_ZERO_RST;
            uio3 <= `SORC_ZERO_RST;
          end
        `SORC_ADDR_PMODE: pmode <= wr_data[1:0];
        `SORC_ADDR_SERCTL: serctl <= wr_data; // RULE2
        `SORC_ADDR_XFER:
          if (wr_data[`SORC_XFER_BIT])
            ovr_active <= ovr_pending; // RULE6
        `SORC_ADDR_OVR: ovr_pending <= wr_data; // RULE6
        `SORC_ADDR_UIO2: uio2 <= {7'h00, wr_data[`SORC_PULLDN_BIT]}; // RULE8
        `SORC_ADDR_UIO3: uio3 <= {4'h0, wr_data[`SORC_VCM_PD_BIT], 3'h0}; // RULE9
        default: ;
      endcase
    end
  end

  // Initialization sequencer; leaving digital reset re-runs it
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= sorc_pkg::sorc_st_init;
      init_cnt <= '0;
    end
    else
    begin
      case (state)
        sorc_pkg::sorc_st_init:
          if (pmode == sorc_pkg::sorc_pm_dreset)
            state <= sorc_pkg::sorc_st_hold; // RULE14
          else if (init_cnt == ($clog2(INIT_CYCLES+1))'(INIT_CYCLES - 1))
            state <= sorc_pkg::sorc_st_run; // RULE11
          else
            init_cnt <= init_cnt + 1'b1; // RULE11
        sorc_pkg::sorc_st_run:
          if (pmode == sorc_pkg::sorc_pm_dreset)
            state <= sorc_pkg::sorc_st_hold; // RULE14
        sorc_pkg::sorc_st_hold:
          if (pmode != sorc_pkg::sorc_pm_dreset)
          begin
            state <= sorc_pkg::sorc_st_init; // RULE11
            init_cnt <= '0;
          end
        default: state <= sorc_pkg::sorc_st_init;
      endcase
    end
  end

  assign run = state == sorc_pkg::sorc_st_run && pmode == sorc_pkg::sorc_pm_normal; // RULE15
  // Standby freezes the serializer; power-down and digital reset flush it
  assign dp_clear = state != sorc_pkg::sorc_st_run || pmode == sorc_pkg::sorc_pm_pdown
    || pmode == sorc_pkg::sorc_pm_dreset; // RULE14
  assign cur_fmt = decode_fmt(serctl);
  assign last_slot = busy && bit_idx == last_idx(fmt) && (!fmt.ddr ? half : 1'b1);
  assign fifo_pop = run && fifo_valid && (!busy || last_slot);

  sorc_fifo #(.WIDTH(28), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst(rst),
    .flush(dp_clear),
    .in_valid(sample_valid),
    .in_data({sample_a, sample_b}),
    .in_ready(sample_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // Serializer; format is latched per sample so a mid-word change waits
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'b0;
      half <= 1'b0;
      frame_phase <= 1'b0;
      bit_idx <= 4'h0;
      fmt <= '0;
      word_a <= 16'h0000;
      word_b <= 16'h0000;
    end
    else if (dp_clear)
    begin
      busy <= 1'b0; // RULE14
      half <= 1'b0;
      frame_phase <= 1'b0;
      bit_idx <= 4'h0;
    end
    else if (run)
    begin
      if (fifo_pop)
      begin
        busy <= 1'b1;
        half <= 1'b0;
        bit_idx <= 4'h0;
        fmt <= cur_fmt;
        frame_phase <= ~frame_phase; // RULE3
        word_a <= fmt_word(fifo_data[27:14], cur_fmt.w12, ovr_active[`SORC_RES_MSB:`SORC_RES_LSB]);
        word_b <= fmt_word(fifo_data[13:0], cur_fmt.w12, ovr_active[`SORC_RES_MSB:`SORC_RES_LSB]);
      end
      else if (last_slot)
        busy <= 1'b0;
      else if (busy && !fmt.ddr && !half)
        half <= 1'b1; // RULE2
      else if (busy)
      begin
        half <= 1'b0;
        bit_idx <= bit_idx + 4'h1;
      end
    end
  end

  // Lane and clock outputs; SDR holds each bit two cycles, doubling the clock multiple
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      lane_a <= 2'h0;
      lane_b <= 2'h0;
      bit_capture_clock_out <= 1'b0;
      word_marker_clock_out <= 1'b0;
    end
    else if (!run || !busy)
    begin
      lane_a <= 2'h0; // RULE14
      lane_b <= 2'h0;
      bit_capture_clock_out <= 1'b0;
      word_marker_clock_out <= 1'b0;
    end
    else
    begin
      lane_a <= lane_bits(word_a, fmt, bit_idx); // RULE4
      lane_b <= lane_bits(word_b, fmt, bit_idx);
      bit_capture_clock_out <= ~bit_capture_clock_out; // RULE15
      word_marker_clock_out <= fmt.dbl ? frame_phase : bit_idx <= (last_idx(fmt) >> 1); // RULE3
    end
  end

  // Static controls and status
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      common_mode_voltage_output_en <= 1'b1;
      sdio_pulldown_en <= 1'b1;
      max_rate_code <= 3'h0;
      init_done <= 1'b0;
      datapath_in_reset <= 1'b1;
    end
    else
    begin
      common_mode_voltage_output_en <= ~uio3[`SORC_VCM_PD_BIT]; // RULE9
      sdio_pulldown_en <= ~uio2[`SORC_PULLDN_BIT]; // RULE8
      max_rate_code <= ovr_active[`SORC_RATE_MSB:0]; // RULE7
      init_done <= state == sorc_pkg::sorc_st_run; // RULE11
      datapath_in_reset <= dp_clear;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_ovr_commit;
    wr_en && spi_addr == `SORC_ADDR_XFER && wr_data[`SORC_XFER_BIT];
  endsequence
  sequence s_leave_dreset;
    state == sorc_pkg::sorc_st_hold && pmode != sorc_pkg::sorc_pm_dreset;
  endsequence

  a_serctl_reset_val: assert property ($fell(rst) |-> serctl == 8'h30) // RULE1
    else $error("serialization control not at default after reset");
  // Soft reset also clears the active override, so it is left out here
  a_ovr_held_pending: assert property (!(wr_en && (spi_addr == `SORC_ADDR_XFER
      || spi_addr == `SORC_ADDR_CFG)) |=> $stable(ovr_active)) // RULE6
    else $error("override changed without transfer");
  a_ovr_commit_copy: assert property (s_ovr_commit |=> ovr_active == $past(ovr_pending)) // RULE6
    else $error("transfer did not commit override");
  a_rate_code_out: assert property (1'b1 |=> max_rate_code == $past(ovr_active[2:0])) // RULE7
    else $error("rate limit output mismatch");
  a_pulldown_ctl: assert property (uio2[0] |=> !sdio_pulldown_en) // RULE8
    else $error("pull-down not released");
  a_vcm_power_down: assert property (uio3[3] |=> !common_mode_voltage_output_en) // RULE9
    else $error("common-mode generator not powered down");
  a_init_after_dreset: assert property (s_leave_dreset |=> !init_done [*2] ##0
      state == sorc_pkg::sorc_st_init) // RULE11
    else $error("initialization not re-run after digital reset");
  a_dreset_quiet: assert property (pmode == 2'h3 |=> ##1 (lane_a == 2'h0 && lane_b == 2'h0
      && !bit_capture_clock_out && !word_marker_clock_out)) // RULE14
    else $error("outputs active during digital reset");
  a_spi_in_dreset: assert property (pmode == 2'h3 && wr_en && spi_addr == `SORC_ADDR_SERCTL
      |=> serctl == $past(wr_data)) // RULE14
    else $error("serial port blocked in digital reset");
  a_clk_runs_normal: assert property (run && busy && !dp_clear ##1 run && busy
      |=> bit_capture_clock_out != $past(bit_capture_clock_out)) // RULE15
    else $error("bit clock stalled in normal mode");
  a_reserved_default: assert property ((serctl & 8'hC9) != 8'h00 && serctl != 8'h40
      && serctl != 8'h42 |-> cur_fmt == 5'h06) // RULE16
    else $error("reserved code not mapped to default");
endmodule

// ### tb/serial_output_mode_and_reset_control_tb.sv
`include "sorc_regs.svh"

module serial_output_mode_and_reset_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int INIT_N = 4;
  localparam logic [13:0] SMP_A = 14'h2D35;
  localparam logic [13:0] SMP_B = 14'h1A4B;
  localparam logic [7:0] CODES [18] = '{8'h30, 8'h20, 8'h10, 8'h00, 8'h32, 8'h22, 8'h12,
    8'h02, 8'h40, 8'h42, 8'h34, 8'h24, 8'h14, 8'h04, 8'h36, 8'h26, 8'h16, 8'h06};
  logic sys_clk, rst, spi_sclk, spi_csb_n, spi_sdio_in, spi_sdio_out, spi_sdio_oe;
  logic sample_valid, sample_ready, bit_capture_clock_out, word_marker_clock_out;
  logic common_mode_voltage_output_en, sdio_pulldown_en, init_done, datapath_in_reset;
  logic [13:0] sample_a, sample_b;
  logic [1:0] lane_a, lane_b;
  logic [2:0] max_rate_code;
  int error_cnt = 0;
  int num_checks = 0;

  sorc_top #(.INIT_CYCLES(INIT_N), .FIFO_DEPTH(16)) uut (
    .sys_clk(sys_clk), .rst(rst), .spi_sclk(spi_sclk), .spi_csb_n(spi_csb_n),
    .spi_sdio_in(spi_sdio_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
    .sample_ready(sample_ready), .lane_a(lane_a), .lane_b(lane_b),
    .bit_capture_clock_out(bit_capture_clock_out),
    .word_marker_clock_out(word_marker_clock_out),
    .common_mode_voltage_output_en(common_mode_voltage_output_en),
    .sdio_pulldown_en(sdio_pulldown_en), .max_rate_code(max_rate_code),
    .init_done(init_done), .datapath_in_reset(datapath_in_reset));

  sorc_host_model host (
    .sys_clk(sys_clk), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe(spi_sdio_oe),
    .sdio_pulldown_en(sdio_pulldown_en), .lane_a(lane_a), .lane_b(lane_b),
    .word_marker_clock_out(word_marker_clock_out), .spi_sclk(spi_sclk),
    .spi_csb_n(spi_csb_n), .spi_sdio_in(spi_sdio_in));

  // Converter clock, 100 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] unused;
    host.xfer(1'b0, a, d, unused);
  endtask

  task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.xfer(1'b1, a, 8'h00, v);
    check($sformatf("register %h", a), {8'h00, e}, {8'h00, v});
  endtask

  task automatic push(input logic [13:0] a, input logic [13:0] b);
    sample_a = a;
    sample_b = b;
    sample_valid = 1'b1;
    @(negedge sys_clk);
    sample_valid = 1'b0;
  endtask

  // Bits per lane: one-lane codes carry the whole word on one lane, two-lane codes half on each
  function automatic int nbits(input logic [7:0] c);
    return c[6] ? (c[1] ? 12 : 16) : (c[1] ? 6 : 8);
  endfunction

  // Expected lane pattern, word left-justified in 16 bits
  function automatic logic [15:0] lane_exp(input logic [7:0] c, input logic [13:0] s,
    input logic up);
    logic [15:0] w;
    logic [15:0] r;
    w = c[1] ? {s[13:2], 4'h0} : {s, 2'b00};
    r = '0;
    for (int k = 0; k < nbits(c); k++)
      if (c[6])
        r = {r[14:0], up ? 1'b0 : w[15-k]};
      else if (c[4])
        r = {r[14:0], up ? w[15-k] : w[15-nbits(c)-k]};
      else
        r = {r[14:0], up ? w[15-2*k] : w[14-2*k]};
    return r;
  endfunction

  // Send one sample pair and compare all four lanes for format c
  task automatic word_chk(input logic [7:0] c);
    logic [15:0] ua, la, ub, lb;
    push(SMP_A, SMP_B);
    host.grab(nbits(c), (c[5] | c[6]) ? 1 : 2, ua, la, ub, lb);
    check($sformatf("upper a %h", c), lane_exp(c, SMP_A, 1'b1), ua);
    check($sformatf("lower a %h", c), lane_exp(c, SMP_A, 1'b0), la);
    check($sformatf("upper b %h", c), lane_exp(c, SMP_B, 1'b1), ub);
    check($sformatf("lower b %h", c), lane_exp(c, SMP_B, 1'b0), lb);
  endtask

  // Start-up timing and power-on register values
  task automatic t_reset();
    repeat (INIT_N) @(negedge sys_clk);
    check("init_done early", 16'h0, {15'h0, init_done});
    repeat (2) @(negedge sys_clk);
    check("init_done", 16'h1, {15'h0, init_done});
    check("datapath reset", 16'h0, {15'h0, datapath_in_reset});
    check("pull-down", 16'h1, {15'h0, sdio_pulldown_en});
    check("common mode", 16'h1, {15'h0, common_mode_voltage_output_en});
    rd_chk(`SORC_ADDR_SERCTL, 8'h30);
    word_chk(8'h30);
  endtask

  // Every serialization code; single frame ones are also checked on the lanes
  task automatic t_formats();
    for (int j = 0; j < 18; j++)
    begin
      wr(`SORC_ADDR_SERCTL, CODES[j]);
      rd_chk(`SORC_ADDR_SERCTL, CODES[j]);
      if (CODES[j][2] == 1'b0)
        word_chk(CODES[j]);
    end
    wr(`SORC_ADDR_SERCTL, 8'h08);
    rd_chk(`SORC_ADDR_SERCTL, 8'h08);
    word_chk(8'h30);
  endtask

  // Override stays pending until the transfer strobe; unmapped space is inert
  task automatic t_override();
    wr(`SORC_ADDR_OVR, 8'h05);
    check("rate pending", 16'h0, {13'h0, max_rate_code});
    rd_chk(`SORC_ADDR_OVR, 8'h05);
    wr(`SORC_ADDR_XFER, 8'h01);
    check("rate active", 16'h5, {13'h0, max_rate_code});
    wr(`SORC_ADDR_OVR, 8'h02);
    check("rate held", 16'h5, {13'h0, max_rate_code});
    rd_chk(`SORC_ADDR_XFER, 8'h00);
    wr(13'h050, 8'hA5);
    rd_chk(13'h050, 8'h00);
  endtask

  // Unused bits of the user I/O registers read back as zero
  task automatic t_uio();
    wr(`SORC_ADDR_UIO2, 8'hFF);
    rd_chk(`SORC_ADDR_UIO2, 8'h01);
    check("pull-down off", 16'h0, {15'h0, sdio_pulldown_en});
    wr(`SORC_ADDR_UIO3, 8'hFF);
    rd_chk(`SORC_ADDR_UIO3, 8'h08);
    check("common mode off", 16'h0, {15'h0, common_mode_voltage_output_en});
  endtask

  // Soft reset, then digital reset and back to normal running
  task automatic t_recover();
    wr(`SORC_ADDR_SERCTL, 8'h20);
    wr(`SORC_ADDR_CFG, 8'h3C);
    rd_chk(`SORC_ADDR_SERCTL, 8'h30);
    check("pull-down back", 16'h1, {15'h0, sdio_pulldown_en});
    wr(`SORC_ADDR_PMODE, 8'h03);
    wr(`SORC_ADDR_SERCTL, 8'h20);
    check("datapath held", 16'h1, {15'h0, datapath_in_reset});
    rd_chk(`SORC_ADDR_SERCTL, 8'h20);
    push(SMP_A, SMP_B);
    for (int k = 0; k < 16; k++)
    begin
      check("quiet outputs", 16'h0, {10'h0, lane_a, lane_b, bit_capture_clock_out,
        word_marker_clock_out});
      @(negedge sys_clk);
    end
    wr(`SORC_ADDR_PMODE, 8'h00);
    for (int t = 0; t < 60 && init_done !== 1'b1; t++)
      @(negedge sys_clk);
    check("init again", 16'h1, {15'h0, init_done});
    check("datapath free", 16'h0, {15'h0, datapath_in_reset});
    word_chk(8'h20);
  endtask

  // Pushing every cycle outruns the lanes, so the buffer must fill, then drain
  task automatic t_fifo();
    int k;
    sample_a = SMP_A;
    sample_b = SMP_B;
    sample_valid = 1'b1;
    for (k = 0; k < 60 && sample_ready === 1'b1; k++)
      @(negedge sys_clk);
    sample_valid = 1'b0;
    check("fill count", 16'h1, {15'h0, k >= 16 && k < 60});
    for (k = 0; k < 400 && sample_ready !== 1'b1; k++)
      @(negedge sys_clk);
    check("drained", 16'h1, {15'h0, sample_ready});
  endtask

  initial
  begin
    rst = 1'b1;
    sample_valid = 1'b0;
    sample_a = '0;
    sample_b = '0;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    t_reset();
    t_formats();
    t_override();
    t_uio();
    t_recover();
    t_fifo();
    conclude();
  end

  // Run needs about 1.2 ms; a hang is cut off well past that
  initial
  begin
    #4_000_000;
    error_cnt++;
    conclude();
  end
endmodule

// ### tb/sorc_host_model.sv
module sorc_host_model (
  input wire logic sys_clk,
  input wire logic spi_sdio_out,
  input wire logic spi_sdio_oe,
  input wire logic sdio_pulldown_en,
  input wire logic [1:0] lane_a,
  input wire logic [1:0] lane_b,
  input wire logic word_marker_clock_out,
  output logic spi_sclk,
  output logic spi_csb_n,
  output logic spi_sdio_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_oe;
  logic host_bit;

  // Shared data wire; nobody driving and no pull-down means a flipped last bit
  assign spi_sdio_in = host_oe ? host_bit : spi_sdio_oe ? spi_sdio_out :
    sdio_pulldown_en ? 1'b0 : ~host_bit;

  // Port parked: select high, serial clock low
  initial
  begin
    spi_sclk = 1'b0;
    spi_csb_n = 1'b1;
    host_oe = 1'b0;
    host_bit = 1'b0;
  end

  // One 24-bit frame at an 800 ns serial clock, bits moved while the clock is low
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdat,
    output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {rd, 2'b00, addr, wdat};
    rdat = 8'h00;
    spi_csb_n = 1'b0;
    host_oe = 1'b1;
    for (int i = 23; i >= 0; i--)
    begin
      if (rd && i < 8)
        host_oe = 1'b0;
      else
        host_bit = frame[i];
      repeat (4) @(negedge sys_clk);
      spi_sclk = 1'b1;
      repeat (4) @(negedge sys_clk);
      // Latest point before the falling edge moves the read bit on
      if (rd && i < 8)
        rdat[i] = spi_sdio_oe ? spi_sdio_out : 1'bx;
      spi_sclk = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    spi_csb_n = 1'b1;
    host_oe = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask

  // Capture one word from its marker, one look per bit slot
  task automatic grab(input int n, input int s, output logic [15:0] ua,
    output logic [15:0] la, output logic [15:0] ub, output logic [15:0] lb);
    int t;
    {ua, la, ub, lb} = '0;
    t = 0;
    while (word_marker_clock_out !== 1'b1 && t < 100)
    begin
      @(negedge sys_clk);
      t++;
    end
    for (int k = 0; k < n; k++)
    begin
      ua = {ua[14:0], lane_a[1]};
      la = {la[14:0], lane_a[0]};
      ub = {ub[14:0], lane_b[1]};
      lb = {lb[14:0], lane_b[0]};
      repeat (s) @(negedge sys_clk);
    end
  endtask
endmodule
